// ===== gate_override_regs.vh
/*
 gate override register map: offsets, field positions, reset values.
 assumes a 32-bit apb slave with byte addresses; included by bare name.
*/
`ifndef GATE_OVERRIDE_REGS_VH
`define GATE_OVERRIDE_REGS_VH

`define CLU_STATUS_OFS 12'hc00
`define CLU_SET_OFS 12'hc04
`define CLU_CLR_OFS 12'hc08
`define CORE_STATUS_OFS 12'hc10
`define CORE_SET_OFS 12'hc14
`define CORE_CLR_OFS 12'hc18
`define CPLX_STATUS_OFS 12'hc20
`define CPLX_SET_OFS 12'hc24
`define CPLX_CLR_OFS 12'hc28
// entry delays, one byte per gated clock class
`define CLU_DELAY_OFS 12'hc30
`define CORE_DELAY_OFS 12'hc34
`define CPLX_DELAY_OFS 12'hc38

`define PERIPH_CLK_BIT 6
`define PROC_CLK_BIT 5
`define DEBUG_CLK_BIT 4
`define INTC_CLK_BIT 3
`define TRACE_CLK_BIT 2
`define PBUS_CLK_BIT 1
`define CLU_MASK 32'h0000007e
`define PER_LO 8
`define PER_HI 23
`define DELAY_LO 24
`define DELAY_HI 31
`define DELAY_RESET 8'hff
`define OVR_RESET 32'h00000000

`endif

// ===== apb_slave_port.v
/*
 apb slave front end: zero-wait answer, decodes write and read strobes.
 assumes apb signalling from a single master on core_clk.
*/
`default_nettype none
`timescale 1ns/1ps
module apb_slave_port (
  // bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  // strobes
  output wire wr_stb,
  output wire rd_stb
);
  // one access cycle per transfer since pready is always high
  assign wr_stb = psel & penable & pwrite;
  assign rd_stb = psel & ~penable & ~pwrite;
endmodule
`default_nettype wire

// ===== gate_delay_timer.v
/*
 one gating-entry timer: request gating a set number of cycles after idle.
 assumes clk_needed is synchronous to core_clk.
*/
`default_nettype none
`timescale 1ns/1ps
module gate_delay_timer (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // control
  input wire clk_needed,
  input wire override,
  input wire [7:0] gating_entry_delay,
  // result
  output reg gate_req_ff
);
  reg [7:0] cnt_ff;
  reg [7:0] nxt_cnt;
  reg nxt_gate_req;

  always @* begin
    nxt_cnt = cnt_ff;
    nxt_gate_req = 1'b0;
    if (override | clk_needed) begin
      nxt_cnt = 8'h00;
    end else if (cnt_ff >= gating_entry_delay) begin
      nxt_gate_req = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + 8'h01;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 8'h00;
      gate_req_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      gate_req_ff <= nxt_gate_req;
    end
  end
endmodule
`default_nettype wire

// ===== clock_gating_force_control.v
/*
 clock gating override bank with per-clock entry delay timers.
 assumes an apb master on core_clk; clock-needed inputs synchronous to it.
*/
`include "gate_override_regs.vh"
`default_nettype none
`timescale 1ns/1ps

// How it works
// - status bit one means gating overridden
// - set register ones force override on
// - clear register ones restore gating
// - cluster bits 6,5,4 peripheral, processor, debug
// - cluster bits 3,2,1 intc, trace, bus
// - cluster bit 0, 31:7 read zero
// - core bits 23:8, others read zero
// - complex bits 23:8, unused read zero
// - override words always present; unused core and complex bits masked by parameter
// - gate request after programmable idle delay
module clock_gating_force_control #(
  parameter [15:0] CORE_USED = 16'hffff,
  parameter [15:0] CPLX_USED = 16'hffff
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // clock demand from the gated domains
  input wire [6:1] cluster_clk_needed,
  input wire [15:0] core_clk_needed,
  input wire [15:0] cplx_clk_needed,
  // gating disable and gating requests
  output reg [6:1] cluster_gate_disable,
  output reg [15:0] core_gate_disable,
  output reg [15:0] cplx_gate_disable,
  output wire [6:1] cluster_gate_req,
  output wire [15:0] core_gate_req,
  output wire [15:0] cplx_gate_req
);
  reg [31:0] clu_ovr_ff;
  reg [31:0] core_ovr_ff;
  reg [31:0] cplx_ovr_ff;
  reg [7:0] clu_delay_ff;
  reg [7:0] core_delay_ff;
  reg [7:0] cplx_delay_ff;
  reg [31:0] nxt_rdata;
  wire wr_stb;
  wire rd_stb;
  wire [31:0] core_mask;
  wire [31:0] cplx_mask;
  // one strobe per writable register, decoded once
  wire clu_set_hit;
  wire clu_clr_hit;
  wire core_set_hit;
  wire core_clr_hit;
  wire cplx_set_hit;
  wire cplx_clr_hit;
  wire clu_delay_hit;
  wire core_delay_hit;
  wire cplx_delay_hit;
  // named view of the cluster override flags
  wire peripheral_clock_override;
  wire cluster_processor_clock_override;
  wire debug_clock_override;
  wire interrupt_ctrl_clock_override;
  wire trace_clock_override;
  wire periph_bus_clock_override;

  assign core_mask = {8'h00, CORE_USED, 8'h00};
  assign cplx_mask = {8'h00, CPLX_USED, 8'h00};

  // a write lands only in the access phase and only on an exact word address
  function wr_hit;
    input stb;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      wr_hit = stb && (addr == ofs);
    end
  endfunction

  // writes to the status words match no strobe, so they are dropped
  assign clu_set_hit = wr_hit(wr_stb, paddr, `CLU_SET_OFS);
  assign clu_clr_hit = wr_hit(wr_stb, paddr, `CLU_CLR_OFS);
  assign core_set_hit = wr_hit(wr_stb, paddr, `CORE_SET_OFS);
  assign core_clr_hit = wr_hit(wr_stb, paddr, `CORE_CLR_OFS);
  assign cplx_set_hit = wr_hit(wr_stb, paddr, `CPLX_SET_OFS);
  assign cplx_clr_hit = wr_hit(wr_stb, paddr, `CPLX_CLR_OFS);
  assign clu_delay_hit = wr_hit(wr_stb, paddr, `CLU_DELAY_OFS);
  assign core_delay_hit = wr_hit(wr_stb, paddr, `CORE_DELAY_OFS);
  assign cplx_delay_hit = wr_hit(wr_stb, paddr, `CPLX_DELAY_OFS);

  assign peripheral_clock_override = clu_ovr_ff[`PERIPH_CLK_BIT];
  assign cluster_processor_clock_override = clu_ovr_ff[`PROC_CLK_BIT];
  assign debug_clock_override = clu_ovr_ff[`DEBUG_CLK_BIT];
  assign interrupt_ctrl_clock_override = clu_ovr_ff[`INTC_CLK_BIT];
  assign trace_clock_override = clu_ovr_ff[`TRACE_CLK_BIT];
  assign periph_bus_clock_override = clu_ovr_ff[`PBUS_CLK_BIT];

  // set wins over clear when both land, though only one register is written per cycle
  function [31:0] apply_ovr;
    input [31:0] cur;
    input [31:0] mask;
    input set_hit;
    input clr_hit;
    input [31:0] data;
    begin
      apply_ovr = cur;
      if (clr_hit) begin
        apply_ovr = apply_ovr & ~(data & mask);
      end
      if (set_hit) begin
        apply_ovr = apply_ovr | (data & mask);
      end
    end
  endfunction

  apb_slave_port u_apb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb)
  );

  // cluster flags; the mask keeps bit 0 and the upper bits at zero
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clu_ovr_ff <= `OVR_RESET;
    end else begin
      clu_ovr_ff <= apply_ovr(clu_ovr_ff, `CLU_MASK, clu_set_hit, clu_clr_hit, pwdata);
    end
  end

  // core flags; unused cores are masked by build parameter
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      core_ovr_ff <= `OVR_RESET;
    end else begin
      core_ovr_ff <= apply_ovr(core_ovr_ff, core_mask, core_set_hit, core_clr_hit, pwdata);
    end
  end

  // complex flags; unused complexes are masked by build parameter
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cplx_ovr_ff <= `OVR_RESET;
    end else begin
      cplx_ovr_ff <= apply_ovr(cplx_ovr_ff, cplx_mask, cplx_set_hit, cplx_clr_hit, pwdata);
    end
  end

  // entry delays reset to the longest wait so nothing gates early after reset
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clu_delay_ff <= `DELAY_RESET;
      core_delay_ff <= `DELAY_RESET;
      cplx_delay_ff <= `DELAY_RESET;
    end else begin
      if (clu_delay_hit) begin
        clu_delay_ff <= pwdata[`DELAY_HI:`DELAY_LO];
      end
      if (core_delay_hit) begin
        core_delay_ff <= pwdata[`DELAY_HI:`DELAY_LO];
      end
      if (cplx_delay_hit) begin
        cplx_delay_ff <= pwdata[`DELAY_HI:`DELAY_LO];
      end
    end
  end

  // status words show the stored flags; write-only and unmapped words read zero
  function [31:0] read_word;
    input [11:0] addr;
    input [31:0] clu;
    input [31:0] core;
    input [31:0] cplx;
    input [7:0] clu_dly;
    input [7:0] core_dly;
    input [7:0] cplx_dly;
    begin
      case (addr)
        `CLU_STATUS_OFS: read_word = clu;
        `CORE_STATUS_OFS: read_word = core;
        `CPLX_STATUS_OFS: read_word = cplx;
        `CLU_SET_OFS: read_word = 32'h00000000;
        `CLU_CLR_OFS: read_word = 32'h00000000;
        `CORE_SET_OFS: read_word = 32'h00000000;
        `CORE_CLR_OFS: read_word = 32'h00000000;
        `CPLX_SET_OFS: read_word = 32'h00000000;
        `CPLX_CLR_OFS: read_word = 32'h00000000;
        `CLU_DELAY_OFS: read_word = {clu_dly, 24'h000000};
        `CORE_DELAY_OFS: read_word = {core_dly, 24'h000000};
        `CPLX_DELAY_OFS: read_word = {cplx_dly, 24'h000000};
        default: read_word = 32'h00000000;
      endcase
    end
  endfunction

  always @* begin
    nxt_rdata = read_word(paddr, clu_ovr_ff, core_ovr_ff, cplx_ovr_ff, clu_delay_ff, core_delay_ff, cplx_delay_ff);
  end

  // read data captured in setup so it stands throughout the access phase
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b1;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      if (rd_stb) begin
        prdata <= nxt_rdata;
      end
    end
  end

  // disables trail the flags by one cycle so every output leaves a flop
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cluster_gate_disable <= 6'h00;
      core_gate_disable <= 16'h0000;
      cplx_gate_disable <= 16'h0000;
    end else begin
      cluster_gate_disable <= {
        peripheral_clock_override,
        cluster_processor_clock_override,
        debug_clock_override,
        interrupt_ctrl_clock_override,
        trace_clock_override,
        periph_bus_clock_override
      };
      core_gate_disable <= core_ovr_ff[`PER_HI:`PER_LO];
      cplx_gate_disable <= cplx_ovr_ff[`PER_HI:`PER_LO];
    end
  end

  // peripheral_clock entry timer
  gate_delay_timer u_periph_timer (
    .core_clk(core_clk),
    .rst(rst),
    .clk_needed(cluster_clk_needed[6]),
    .override(peripheral_clock_override),
    .gating_entry_delay(clu_delay_ff),
    .gate_req_ff(cluster_gate_req[6])
  );

  // cluster processor clock entry timer
  gate_delay_timer u_proc_timer (
    .core_clk(core_clk),
    .rst(rst),
    .clk_needed(cluster_clk_needed[5]),
    .override(cluster_processor_clock_override),
    .gating_entry_delay(clu_delay_ff),
    .gate_req_ff(cluster_gate_req[5])
  );

  // debug_clock entry timer
  gate_delay_timer u_debug_timer (
    .core_clk(core_clk),
    .rst(rst),
    .clk_needed(cluster_clk_needed[4]),
    .override(debug_clock_override),
    .gating_entry_delay(clu_delay_ff),
    .gate_req_ff(cluster_gate_req[4])
  );

  // interrupt_ctrl_clock entry timer
  gate_delay_timer u_intc_timer (
    .core_clk(core_clk),
    .rst(rst),
    .clk_needed(cluster_clk_needed[3]),
    .override(interrupt_ctrl_clock_override),
    .gating_entry_delay(clu_delay_ff),
    .gate_req_ff(cluster_gate_req[3])
  );

  // trace_clock entry timer
  gate_delay_timer u_trace_timer (
    .core_clk(core_clk),
    .rst(rst),
    .clk_needed(cluster_clk_needed[2]),
    .override(trace_clock_override),
    .gating_entry_delay(clu_delay_ff),
    .gate_req_ff(cluster_gate_req[2])
  );

  // cluster peripheral bus clock entry timer
  gate_delay_timer u_pbus_timer (
    .core_clk(core_clk),
    .rst(rst),
    .clk_needed(cluster_clk_needed[1]),
    .override(periph_bus_clock_override),
    .gating_entry_delay(clu_delay_ff),
    .gate_req_ff(cluster_gate_req[1])
  );

  // one timer per core and per complex; all share their group's delay
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_per
      gate_delay_timer u_core (
        .core_clk(core_clk),
        .rst(rst),
        .clk_needed(core_clk_needed[gi]),
        .override(core_ovr_ff[gi + `PER_LO]),
        .gating_entry_delay(core_delay_ff),
        .gate_req_ff(core_gate_req[gi])
      );
      gate_delay_timer u_cplx (
        .core_clk(core_clk),
        .rst(rst),
        .clk_needed(cplx_clk_needed[gi]),
        .override(cplx_ovr_ff[gi + `PER_LO]),
        .gating_entry_delay(cplx_delay_ff),
        .gate_req_ff(cplx_gate_req[gi])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// ===== clock_gating_force_control_assertions.sv
/*
 checker for the gate override bank: apb answer, set and clear effect, read data.
 assumes it is bound to clock_gating_force_control.
*/
`timescale 1ns/1ps
`default_nettype none
module gate_override_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // clock side
  input wire logic [6:1] cluster_clk_needed,
  input wire logic [15:0] core_clk_needed,
  input wire logic [15:0] cplx_clk_needed,
  input wire logic [6:1] cluster_gate_disable,
  input wire logic [15:0] core_gate_disable,
  input wire logic [15:0] cplx_gate_disable,
  input wire logic [6:1] cluster_gate_req,
  input wire logic [15:0] core_gate_req,
  input wire logic [15:0] cplx_gate_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire wr = psel && penable && pwrite;
  wire rs = psel && !penable && !pwrite;
  property p_answer; pready && !pslverr; endproperty
  a_answer: assert property (p_answer) else $error("bus answer late or error");
  property p_clu_set; wr && paddr == 12'hc04 |-> ##2
    (cluster_gate_disable & $past(pwdata[6:1], 2)) == $past(pwdata[6:1], 2); endproperty
  a_clu_set: assert property (p_clu_set) else $error("cluster set lost");
  property p_clu_clr; wr && paddr == 12'hc08 |-> ##2 (cluster_gate_disable & $past(pwdata[6:1], 2)) == 6'h0; endproperty
  a_clu_clr: assert property (p_clu_clr) else $error("cluster clear lost");
  property p_core_set; wr && paddr == 12'hc14 |-> ##2
    (core_gate_disable & $past(pwdata[23:8], 2)) == $past(pwdata[23:8], 2); endproperty
  a_core_set: assert property (p_core_set) else $error("core set lost");
  property p_cplx_clr; wr && paddr == 12'hc28 |-> ##2 (cplx_gate_disable & $past(pwdata[23:8], 2)) == 16'h0; endproperty
  a_cplx_clr: assert property (p_cplx_clr) else $error("complex clear lost");
  property p_rd_stat; rs && paddr == 12'hc00 |=> prdata == {25'h0, cluster_gate_disable, 1'b0}; endproperty
  a_rd_stat: assert property (p_rd_stat) else $error("status read differs");
  property p_rd_wo; rs && paddr == 12'hc14 |=> prdata == 32'h0; endproperty
  a_rd_wo: assert property (p_rd_wo) else $error("set register read nonzero");
  property p_req_drop; 1'b1 |=> ({cluster_gate_req, core_gate_req, cplx_gate_req} & $past({cluster_clk_needed,
    core_clk_needed, cplx_clk_needed} | {cluster_gate_disable, core_gate_disable, cplx_gate_disable})) == 38'h0;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("gating request while needed");
endmodule
bind clock_gating_force_control gate_override_checker i_chk (.*);
`default_nettype wire

// ===== clock_gating_force_control_tb.sv
/*
 testbench for the gate override bank: apb reads queued and checked by a monitor.
 assumes the design answers with zero wait states.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_gating_force_control_tb;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0, b;
  logic [31:0] pwdata = 0, prdata, r;
  logic [6:1] cluster_clk_needed = '1, cluster_gate_disable, cluster_gate_req;
  logic [15:0] core_clk_needed = '1, cplx_clk_needed = '1, core_gate_disable, cplx_gate_disable;
  logic [15:0] core_gate_req, cplx_gate_req;
  logic [31:0] shadow [3];
  logic [31:0] expq [$];
  int failures = 0, n_tests = 0;
  localparam logic [31:0] MASK [3] = '{32'h7e, 32'hffff00, 32'hffff00};
  always #12.5 core_clk = ~core_clk;
  clock_gating_force_control i_dut (.*);
  task chk(input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("mismatches %0d of %0d compares", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    expq.push_back(e);
    xfer(0, a, 32'h0);
  endtask
  // read data is taken at the edge that completes the access phase
  always @(posedge core_clk)
    if (psel && penable && !pwrite && pready) chk(prdata, expq.pop_front());
  initial begin
    r = $urandom(32'h3da9b858);
    repeat (6) @(posedge core_clk);
    rst <= 0;
    for (logic [11:0] a = 12'hc00; a < 12'hc3c; a += 12'h4) rd(a, a >= 12'hc30 ? 32'hff000000 : 0);
    shadow = '{0, 0, 0};
    repeat (2) for (int g = 0; g < 3; g++) begin
      b = 12'hc00 + 12'(g * 16);
      core_clk_needed <= 16'($urandom);
      cplx_clk_needed <= 16'($urandom);
      r = $urandom;
      xfer(1, b + 12'h4, r);
      shadow[g] |= r & MASK[g];
      rd(b, shadow[g]);
      xfer(1, b, '1);
      rd(b, shadow[g]);
      rd(b + 12'h4, 0);
      r = $urandom;
      xfer(1, b + 12'h8, r);
      shadow[g] &= ~(r & MASK[g]);
      rd(b, shadow[g]);
    end
    xfer(1, 12'hc08, '1);
    xfer(1, 12'hc30, 32'h03000000);
    cluster_clk_needed <= '0;
    repeat (2) @(posedge core_clk);
    #1 chk(cluster_gate_req, 0);
    repeat (8) @(posedge core_clk);
    #1 chk(cluster_gate_req, 32'h3f);
    xfer(1, 12'hc04, 32'h40);
    repeat (3) @(posedge core_clk);
    #1 chk(cluster_gate_req, 32'h1f);
    chk(pslverr, 0);
    chk(core_gate_disable, shadow[1][23:8]);
    chk(cplx_gate_disable, shadow[2][23:8]);
    xfer(1, 12'hc34, 32'h02000000);
    xfer(1, 12'hc38, 32'h02000000);
    core_clk_needed <= '0;
    cplx_clk_needed <= '0;
    repeat (8) @(posedge core_clk);
    #1 chk(core_gate_req, {16'h0, ~shadow[1][23:8]});
    chk(cplx_gate_req, {16'h0, ~shadow[2][23:8]});
    report_and_stop;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    report_and_stop;
  end
endmodule
`default_nettype wire
